// file: adc_ctrl_pkg.sv
// Purpose: Shared constants, types and helpers for the converter control block
// Assumes: Single 25 MHz system clock, AXI4-Lite register access
// Notes:   Register byte address is four times the register index
package adc_ctrl_pkg;

	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// Register indices; byte address is index times four
	localparam logic [9:0] IDX_GLOBAL_IRQ = 10'h00b;
	localparam logic [9:0] IDX_REQ_FLAGS  = 10'h00c;
	localparam logic [9:0] IDX_RESULT     = 10'h01e;
	localparam logic [9:0] IDX_CONTROL    = 10'h01f;
	localparam logic [9:0] IDX_REQ_ENABLE = 10'h08c;
	localparam logic [9:0] IDX_PIN_CONFIG = 10'h09f;

	// Field positions
	localparam int POS_GLOBAL_EN  = 7;
	localparam int POS_PERIPH_EN  = 6;
	localparam int POS_CONV_FLAG  = 6;
	localparam int POS_CLK_SEL    = 6;
	localparam int POS_CHAN_SEL   = 3;
	localparam int POS_GO         = 2;
	localparam int POS_POWER      = 0;

	// Reset values
	localparam logic [7:0] RST_CONTROL    = 8'h00;
	localparam logic [7:0] RST_PIN_CONFIG = 8'h00;
	localparam logic [7:0] RST_FLAGS      = 8'h00;
	localparam logic [7:0] RST_ENABLES    = 8'h00;
	localparam logic [7:0] RST_GLOBAL     = 8'h00;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Conversion clock choices
	localparam logic [1:0] CLK_DIV2  = 2'h0;
	localparam logic [1:0] CLK_DIV8  = 2'h1;
	localparam logic [1:0] CLK_DIV32 = 2'h2;
	localparam logic [1:0] CLK_RC    = 2'h3;

	// Timing: system clock and private RC oscillator period
	localparam int CLK_PERIOD_NS = 40;
	localparam int RC_PERIOD_NS  = 4000;
	localparam int RC_DIV = (RC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DIV2  = 2;
	localparam int DIV8  = 8;
	localparam int DIV32 = 32;

	// Control register fields
	typedef struct packed {
		logic [1:0] clk_sel;
		logic [2:0] chan_sel;
		logic       go;
		logic       unused;
		logic       power_on;
	} conv_ctrl_t;

	// Signals toward the analog front end
	typedef struct packed {
		logic       power_on;
		logic       ref_external;
		logic       hold;
		logic       chan_valid;
		logic [2:0] channel;
		logic [7:0] trial;
		logic [7:0] analog_pins;
	} analog_out_t;

	// Pin function code selects port-A bit 3 as external reference
	function automatic logic ext_ref(input logic [2:0] cfg);
		ext_ref = (cfg == 3'h1) || (cfg == 3'h3) || (cfg == 3'h5);
	endfunction : ext_ref

	// Pin function code to analog-input mask, one bit per channel
	function automatic logic [7:0] analog_mask(input logic [2:0] cfg);
		case (cfg)
			3'h0, 3'h1: analog_mask = 8'hff;
			3'h2, 3'h3: analog_mask = 8'h1f;
			3'h4, 3'h5: analog_mask = 8'h0b;
			default:    analog_mask = 8'h00;
		endcase
	endfunction : analog_mask

endpackage : adc_ctrl_pkg

// file: conv_clock_divider.sv
// Purpose: Conversion clock enable from the system clock or the RC divider
// Assumes: Enable is a one-cycle pulse in the system clock domain
// Notes:   Only the RC enable keeps running while the device sleeps
module conv_clock_divider
	import adc_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	// Selection
	input  wire logic [1:0] clk_sel_i,
	input  wire logic       sleep_i,
	// Enable out
	output logic            tick_o
);

	logic [4:0] sys_cnt_reg;
	logic [7:0] rc_cnt_reg;
	logic       rc_tick;
	logic       sys_tick;

	// Free-running system-clock prescaler
	always_ff @(posedge clk_i) begin
		if (!rstn_i)
			sys_cnt_reg <= 5'h00;
		else
			sys_cnt_reg <= sys_cnt_reg + 5'h01;
	end

	// Private RC oscillator model, runs in sleep too
	always_ff @(posedge clk_i) begin
		if (!rstn_i)
			rc_cnt_reg <= 8'h00;
		else if (rc_cnt_reg == 8'(RC_DIV - 1))
			rc_cnt_reg <= 8'h00;
		else
			rc_cnt_reg <= rc_cnt_reg + 8'h01;
	end

	assign rc_tick = (rc_cnt_reg == 8'(RC_DIV - 1));

	// Divided system clock choices
	always_comb begin
		case (clk_sel_i)
			CLK_DIV2:  sys_tick = (sys_cnt_reg[0:0] == 1'(DIV2 - 1));
			CLK_DIV8:  sys_tick = (sys_cnt_reg[2:0] == 3'(DIV8 - 1));
			CLK_DIV32: sys_tick = (sys_cnt_reg == 5'(DIV32 - 1));
			default:   sys_tick = 1'b0;
		endcase
	end

	// Divided choices stop in sleep; RC keeps going
	always_ff @(posedge clk_i) begin
		if (!rstn_i)
			tick_o <= 1'b0;
		else if (clk_sel_i == CLK_RC)
			tick_o <= rc_tick;
		else
			tick_o <= sys_tick && !sleep_i;
	end

endmodule : conv_clock_divider

// file: adc_conversion_control.sv
// Purpose: Register file and successive approximation sequencer
// Assumes: External comparator reports input at or above the trial code
// Notes:   Result register has no reset and reads unknown after power-on
//
// Summary of operation
// - Finished conversion puts unsigned 8-bit code of chosen input in result.
// - Successive approximation decides one bit per step, MSB first.
// - Software picks supply rail or port-A bit 3 pin as reference.
// - In sleep only the private RC clock lets a conversion advance.
// - Five inputs on small variants, eight on large; extra codes there only.
// - Exactly three converter registers: result and two control registers.
// - Control register holds clock, channel, start/status, power; bit 1 unused.
// - Pin configuration register sets analog or digital pins and reference.
// - Result untouched by reset except power-on; control registers clear.
// - Unimplemented bits ignore writes and read as zero.
module adc_conversion_control
	import adc_ctrl_pkg::*;
#(
	parameter bit EIGHT_CHANNELS = 1'b1
)(
	// Clock and reset
	input  wire logic                CLOCK_I,
	input  wire logic                RSTN_I,
	// AXI4-Lite write address and data
	input  wire logic                AWVALID_I,
	output logic                     AWREADY_O,
	input  wire logic [ADDR_W-1:0]   AWADDR_I,
	input  wire logic [2:0]          AWPROT_I,
	input  wire logic                WVALID_I,
	output logic                     WREADY_O,
	input  wire logic [DATA_W-1:0]   WDATA_I,
	input  wire logic [DATA_W/8-1:0] WSTRB_I,
	// AXI4-Lite write response
	output logic                     BVALID_O,
	input  wire logic                BREADY_I,
	output logic [1:0]               BRESP_O,
	// AXI4-Lite read
	input  wire logic                ARVALID_I,
	output logic                     ARREADY_O,
	input  wire logic [ADDR_W-1:0]   ARADDR_I,
	input  wire logic [2:0]          ARPROT_I,
	output logic                     RVALID_O,
	input  wire logic                RREADY_I,
	output logic [DATA_W-1:0]        RDATA_O,
	output logic [1:0]               RRESP_O,
	// Device state and analog front end
	input  wire logic                SLEEP_I,
	input  wire logic                COMP_I,
	output analog_out_t              ANALOG_O,
	// Interrupt
	output logic                     IRQ_O
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SAMPLE,
		ST_STEP
	} conv_state_t;

	// Register storage
	conv_ctrl_t  ctrl_reg;
	logic [1:0]  clk_sel_reg;
	logic [2:0]  chan_sel_reg;
	logic        go_reg;
	logic        power_on_reg;
	logic [2:0]  pin_cfg_reg;
	logic [7:0]  result_reg;
	logic        flag_reg;
	logic        flag_en_reg;
	logic [1:0]  global_reg;

	// Sequencer state
	conv_state_t state_reg;
	logic [7:0]  trial_reg;
	logic [2:0]  bit_idx_reg;
	logic        done_reg;
	logic [7:0]  trial_next;

	// Bus state
	logic              aw_got_reg;
	logic              w_got_reg;
	logic [9:0]        wr_idx_reg;
	logic [7:0]        wr_data_reg;
	logic              wr_lane_reg;
	logic              wr_fire;
	logic              wr_mapped;
	logic [9:0]        rd_idx;
	logic [7:0]        rd_byte;
	logic              rd_mapped;
	logic              conv_tick;

	// Decoded writes
	logic wr_ctrl;
	logic wr_pin;
	logic wr_flag;
	logic wr_enable;
	logic wr_global;
	logic start_req;
	logic stop_req;

	// Conversion clock enable
	conv_clock_divider u_div (
		.clk_i     (CLOCK_I),
		.rstn_i    (RSTN_I),
		.clk_sel_i (ctrl_reg.clk_sel),
		.sleep_i   (SLEEP_I),
		.tick_o    (conv_tick)
	);

	// Map test for a register index
	function automatic logic is_mapped(input logic [9:0] idx);
		case (idx)
			IDX_GLOBAL_IRQ, IDX_REQ_FLAGS, IDX_RESULT,
			IDX_CONTROL, IDX_REQ_ENABLE, IDX_PIN_CONFIG:
				is_mapped = 1'b1;
			default:
				is_mapped = 1'b0;
		endcase
	endfunction : is_mapped

	// Write channel: address and data taken in either order
	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I) begin
			AWREADY_O  <= 1'b0;
			aw_got_reg <= 1'b0;
			wr_idx_reg <= 10'h000;
		end else if (AWVALID_I && AWREADY_O) begin
			AWREADY_O  <= 1'b0;
			aw_got_reg <= 1'b1;
			wr_idx_reg <= AWADDR_I[ADDR_W-1:2];
		end else if (wr_fire) begin
			aw_got_reg <= 1'b0;
		end else if (!aw_got_reg && !BVALID_O) begin
			AWREADY_O  <= 1'b1;
		end
	end

	// Write data capture, low byte lane only
	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I) begin
			WREADY_O    <= 1'b0;
			w_got_reg   <= 1'b0;
			wr_data_reg <= 8'h00;
			wr_lane_reg <= 1'b0;
		end else if (WVALID_I && WREADY_O) begin
			WREADY_O    <= 1'b0;
			w_got_reg   <= 1'b1;
			wr_data_reg <= WDATA_I[7:0];
			wr_lane_reg <= WSTRB_I[0];
		end else if (wr_fire) begin
			w_got_reg   <= 1'b0;
		end else if (!w_got_reg && !BVALID_O) begin
			WREADY_O    <= 1'b1;
		end
	end

	// Perform the write once both halves are in
	assign wr_fire   = aw_got_reg && w_got_reg && !BVALID_O;
	assign wr_mapped = is_mapped(wr_idx_reg);
	assign wr_ctrl   = wr_fire && wr_lane_reg && (wr_idx_reg == IDX_CONTROL);
	assign wr_pin    = wr_fire && wr_lane_reg && (wr_idx_reg == IDX_PIN_CONFIG);
	assign wr_flag   = wr_fire && wr_lane_reg && (wr_idx_reg == IDX_REQ_FLAGS);
	assign wr_enable = wr_fire && wr_lane_reg && (wr_idx_reg == IDX_REQ_ENABLE);
	assign wr_global = wr_fire && wr_lane_reg && (wr_idx_reg == IDX_GLOBAL_IRQ);

	// Write response
	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I) begin
			BVALID_O <= 1'b0;
			BRESP_O  <= RESP_OKAY;
		end else if (wr_fire) begin
			BVALID_O <= 1'b1;
			BRESP_O  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (BVALID_O && BREADY_I) begin
			BVALID_O <= 1'b0;
		end
	end

	// Read data multiplexer; unused bits read as zero
	assign rd_idx    = ARADDR_I[ADDR_W-1:2];
	assign rd_mapped = is_mapped(rd_idx);
	always_comb begin
		rd_byte = 8'h00;
		case (rd_idx)
			IDX_RESULT:     rd_byte = result_reg;
			IDX_CONTROL:    rd_byte = {ctrl_reg.clk_sel, ctrl_reg.chan_sel,
					ctrl_reg.go, 1'b0, ctrl_reg.power_on};
			IDX_PIN_CONFIG: rd_byte = {5'h00, pin_cfg_reg};
			IDX_REQ_FLAGS:  rd_byte = 8'(flag_reg) << POS_CONV_FLAG;
			IDX_REQ_ENABLE: rd_byte = 8'(flag_en_reg) << POS_CONV_FLAG;
			IDX_GLOBAL_IRQ: rd_byte = {global_reg, 6'h00};
			default:        rd_byte = 8'h00;
		endcase
	end

	// Read channel: one read under way at a time
	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I) begin
			ARREADY_O <= 1'b0;
			RVALID_O  <= 1'b0;
			RDATA_O   <= '0;
			RRESP_O   <= RESP_OKAY;
		end else if (ARVALID_I && ARREADY_O) begin
			ARREADY_O <= 1'b0;
			RVALID_O  <= 1'b1;
			RDATA_O   <= {24'h000000, rd_byte};
			RRESP_O   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (RVALID_O && RREADY_I) begin
			RVALID_O  <= 1'b0;
		end else if (!RVALID_O) begin
			ARREADY_O <= 1'b1;
		end
	end

	// Control fields other than start/status; bit 1 stays zero
	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I) begin
			clk_sel_reg  <= RST_CONTROL[POS_CLK_SEL+:2];
			chan_sel_reg <= RST_CONTROL[POS_CHAN_SEL+:3];
			power_on_reg <= RST_CONTROL[POS_POWER];
		end else if (wr_ctrl) begin
			clk_sel_reg  <= wr_data_reg[POS_CLK_SEL+:2];
			chan_sel_reg <= wr_data_reg[POS_CHAN_SEL+:3];
			power_on_reg <= wr_data_reg[POS_POWER];
		end
	end

	// Packed view of the control fields; one driver per field flop
	assign ctrl_reg = '{clk_sel: clk_sel_reg, chan_sel: chan_sel_reg,
		go: go_reg, unused: 1'b0, power_on: power_on_reg};

	// Pin configuration, only the low three bits exist
	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I)
			pin_cfg_reg <= RST_PIN_CONFIG[2:0];
		else if (wr_pin)
			pin_cfg_reg <= wr_data_reg[2:0];
	end

	// Start needs power in the same write; clearing the bit aborts
	assign start_req = wr_ctrl && wr_data_reg[POS_GO] && wr_data_reg[POS_POWER];
	assign stop_req  = !ctrl_reg.power_on ||
		(wr_ctrl && (!wr_data_reg[POS_GO] || !wr_data_reg[POS_POWER]));

	// Trial code with the current bit decided by the comparator
	always_comb begin
		trial_next = trial_reg;
		trial_next[bit_idx_reg] = COMP_I;
		if (bit_idx_reg != 3'h0)
			trial_next[bit_idx_reg - 3'h1] = 1'b1;
	end

	// Successive approximation sequencer paced by the conversion clock
	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I) begin
			state_reg   <= ST_IDLE;
			go_reg      <= RST_CONTROL[POS_GO];
			trial_reg   <= 8'h00;
			bit_idx_reg <= 3'h0;
			done_reg    <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (start_req && !ctrl_reg.go) begin
						go_reg      <= 1'b1;
						state_reg   <= ST_SAMPLE;
					end
				end
				ST_SAMPLE: begin
					if (stop_req) begin
						go_reg      <= 1'b0;
						state_reg   <= ST_IDLE;
					end else if (conv_tick) begin
						trial_reg   <= 8'h80;
						bit_idx_reg <= 3'h7;
						state_reg   <= ST_STEP;
					end
				end
				ST_STEP: begin
					if (stop_req) begin
						go_reg      <= 1'b0;
						state_reg   <= ST_IDLE;
					end else if (conv_tick) begin
						trial_reg <= trial_next;
						if (bit_idx_reg == 3'h0) begin
							go_reg      <= 1'b0;
							done_reg    <= 1'b1;
							state_reg   <= ST_IDLE;
						end else begin
							bit_idx_reg <= bit_idx_reg - 3'h1;
						end
					end
				end
				default: begin
					go_reg      <= 1'b0;
					state_reg   <= ST_IDLE;
				end
			endcase
		end
	end

	// Result loaded at completion; no reset, so other resets keep it
	always_ff @(posedge CLOCK_I) begin
		if (state_reg == ST_STEP && conv_tick && !stop_req &&
				bit_idx_reg == 3'h0)
			result_reg <= trial_next;
	end

	// Completion flag: write one clears, a new completion wins
	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I)
			flag_reg <= RST_FLAGS[POS_CONV_FLAG];
		else if (done_reg)
			flag_reg <= 1'b1;
		else if (wr_flag && wr_data_reg[POS_CONV_FLAG])
			flag_reg <= 1'b0;
	end

	// Interrupt enables: per-source mask and the two global gates
	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I) begin
			flag_en_reg <= RST_ENABLES[POS_CONV_FLAG];
			global_reg  <= RST_GLOBAL[POS_PERIPH_EN+:2];
		end else begin
			if (wr_enable)
				flag_en_reg <= wr_data_reg[POS_CONV_FLAG];
			if (wr_global)
				global_reg <= wr_data_reg[POS_PERIPH_EN+:2];
		end
	end

	// Level interrupt from flops
	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I)
			IRQ_O <= 1'b0;
		else
			IRQ_O <= flag_reg && flag_en_reg && (&global_reg);
	end

	// Analog front end drive, registered
	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I) begin
			ANALOG_O <= '0;
		end else begin
			ANALOG_O.power_on     <= ctrl_reg.power_on;
			ANALOG_O.ref_external <= ext_ref(pin_cfg_reg);
			ANALOG_O.hold         <= (state_reg == ST_STEP);
			ANALOG_O.channel      <= ctrl_reg.chan_sel;
			ANALOG_O.chan_valid   <= EIGHT_CHANNELS ||
				(ctrl_reg.chan_sel < 3'h5);
			ANALOG_O.trial        <= trial_reg;
			ANALOG_O.analog_pins  <= analog_mask(pin_cfg_reg) &
				(EIGHT_CHANNELS ? 8'hff : 8'h1f);
		end
	end

endmodule : adc_conversion_control

// file: adc_input_model.sv
// Purpose: Analog input pins and comparator seen by the converter
// Assumes: One held level per channel, set by the bench
// Notes:   Output scrambles whenever no sample is held
module adc_input_model
	import adc_ctrl_pkg::*;
(
	// Clock
	input  wire logic        clk_i,
	// Front end view and pin levels
	input  wire analog_out_t front_i,
	input  wire logic [7:0]  levels_i [8],
	// Comparator
	output logic             comp_o
);
	logic toggle = 1'b0;

	// Changing pattern so an idle comparator never looks settled
	always_ff @(posedge clk_i) begin
		toggle <= !toggle;
	end

	// Held level of the chosen pin against the trial code
	always_comb begin
		comp_o = toggle;
		if (front_i.hold && front_i.power_on && front_i.chan_valid) begin
			comp_o = levels_i[front_i.channel] >= front_i.trial;
		end
	end
endmodule : adc_input_model

// file: adc_conversion_control_asserts.sv
// Purpose: Port-level checks for the converter control block
// Assumes: Single clock, synchronous active-low reset
// Notes:   Bound to every instance of the top module
module adc_ctrl_checker
	import adc_ctrl_pkg::*;
#(
	parameter bit EIGHT_CHANNELS = 1'b1
)(
	// Clock, reset and bus
	input wire logic              CLOCK_I,
	input wire logic              RSTN_I,
	input wire logic              AWREADY_O,
	input wire logic              WREADY_O,
	input wire logic              BVALID_O,
	input wire logic              RVALID_O,
	input wire logic              RREADY_I,
	input wire logic [DATA_W-1:0] RDATA_O,
	// Front end and interrupt
	input wire analog_out_t       ANALOG_O,
	input wire logic              IRQ_O
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RSTN_I);

	a_rdata_upper: assert property (
		RVALID_O |-> RDATA_O[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_rdata_holds: assert property (
		RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
		else $error("read answer dropped before taken");
	a_write_refused: assert property (
		BVALID_O |-> !AWREADY_O && !WREADY_O)
		else $error("write accepted while response pending");
	a_hold_powered: assert property (
		ANALOG_O.hold |-> ANALOG_O.power_on)
		else $error("conversion running while powered off");
	a_msb_first: assert property (
		$rose(ANALOG_O.hold) |-> ANALOG_O.trial == 8'h80)
		else $error("first trial is not the top bit");
	a_conv_bounded: assert property (
		$rose(ANALOG_O.hold) |-> ##[1:1000] !ANALOG_O.hold)
		else $error("conversion never finished");
	a_chan_exists: assert property (
		ANALOG_O.chan_valid |-> EIGHT_CHANNELS || ANALOG_O.channel < 3'h5)
		else $error("missing channel marked valid");
	a_ref_analog: assert property (
		ANALOG_O.ref_external |-> ANALOG_O.analog_pins[3])
		else $error("reference pin left digital");
	a_irq_reset: assert property (
		$rose(RSTN_I) |-> !IRQ_O)
		else $error("interrupt high right after reset");
endmodule : adc_ctrl_checker

bind adc_conversion_control adc_ctrl_checker #(
	.EIGHT_CHANNELS(EIGHT_CHANNELS)
) chk_u (.CLOCK_I, .RSTN_I, .AWREADY_O, .WREADY_O, .BVALID_O, .RVALID_O,
	.RREADY_I, .RDATA_O, .ANALOG_O, .IRQ_O);

// file: adc_conversion_control_bench.sv
// Purpose: Register-level tests of the converter control block
// Assumes: AXI4-Lite master tasks, comparator model on the far side
// Notes:   Bus inputs change only by non-blocking assignment at posedge
module adc_conversion_control_bench;
	import adc_ctrl_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk = 0, rstn = 0, awv = 0, wv = 0, bready = 0;
	logic arv = 0, rready = 0, sleep = 0, comp;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [DATA_W-1:0] wdata = '0, rdata;
	logic [1:0]        bresp, rresp;
	logic [7:0]        lv [8];
	analog_out_t       ana;
	int                n_fail = 0, compares = 0;
	// Expected pin masks per config code; reference codes 1, 3, 5
	logic [7:0] msk [8] = '{8'hff, 8'hff, 8'h1f, 8'h1f, 8'h0b, 8'h0b, 0, 0};
	logic [7:0] ext = 8'h2a;

	always #20 clk = ~clk;

	adc_conversion_control dut_u (.CLOCK_I(clk), .RSTN_I(rstn),
		.AWVALID_I(awv), .AWREADY_O(awready), .AWADDR_I(awaddr),
		.AWPROT_I(3'h0), .WVALID_I(wv), .WREADY_O(wready), .WDATA_I(wdata),
		.WSTRB_I(4'hf), .BVALID_O(bvalid), .BREADY_I(bready),
		.BRESP_O(bresp), .ARVALID_I(arv), .ARREADY_O(arready),
		.ARADDR_I(araddr), .ARPROT_I(3'h0), .RVALID_O(rvalid),
		.RREADY_I(rready), .RDATA_O(rdata), .RRESP_O(rresp),
		.SLEEP_I(sleep), .COMP_I(comp), .ANALOG_O(ana), .IRQ_O(irq));
	adc_input_model model_u (.clk_i(clk), .front_i(ana), .levels_i(lv),
		.comp_o(comp));

	// Verdict and end of run
	task automatic tally_and_finish;
		$display("Compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [31:0] e, s);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic tmo;
		n_fail++;
		$display("Error handshake expected answer seen none");
		tally_and_finish();
	endtask : tmo

	// One AXI write; address and data released as each is taken
	task automatic wr(input logic [9:0] idx, input logic [7:0] d,
		input logic [1:0] er = RESP_OKAY);
		int n;
		logic a, w, b;
		logic [1:0] r;
		n = 0;
		b = 0;
		@(posedge clk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		awv <= 1;
		wv <= 1;
		bready <= 1;
		while (!b) begin
			@(negedge clk);
			a = awv && awready;
			w = wv && wready;
			b = bvalid;
			r = bresp;
			@(posedge clk);
			if (a) awv <= 0;
			if (w) wv <= 0;
			if (b) bready <= 0;
			n++;
			if (n > 200) tmo();
		end
		chk("bresp", {30'h0, er}, {30'h0, r});
	endtask : wr

	// One AXI read; a nonzero lag holds off rready for one cycle more than lag
	task automatic rd(input logic [9:0] idx, output logic [31:0] d,
		input logic [1:0] er = RESP_OKAY, input int lag = 0);
		int n;
		logic a, v;
		logic [1:0] r;
		n = 0;
		v = 0;
		@(posedge clk);
		araddr <= {idx, 2'b00};
		arv <= 1;
		rready <= (lag == 0);
		while (!v) begin
			@(negedge clk);
			a = arv && arready;
			v = rvalid && rready;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (a) arv <= 0;
			if (v) rready <= 0;
			else if (n >= lag) rready <= 1;
			n++;
			if (n > 200) tmo();
		end
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask : rd

	task automatic rdchk(input string nm, input logic [9:0] idx,
		input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
		logic [31:0] d;
		rd(idx, d, er);
		chk(nm, e, d);
	endtask : rdchk

	// Poll the start bit until hardware clears it
	task automatic wait_done;
		int n;
		logic [31:0] d;
		n = 0;
		d = 32'h4;
		while (d[2] === 1'b1) begin
			rd(IDX_CONTROL, d);
			n++;
			if (n > 400) tmo();
		end
	endtask : wait_done

	task automatic nap;
		repeat (3) @(negedge clk);
	endtask : nap

	// Main sequence
	initial begin
		logic [9:0] regs [5];
		logic [2:0] ch;
		logic [31:0] d;
		regs = '{IDX_CONTROL, IDX_PIN_CONFIG, IDX_REQ_FLAGS,
			IDX_REQ_ENABLE, IDX_GLOBAL_IRQ};
		lv = '{8'h00, 8'hff, 8'h80, 8'h7f, 8'h55, 8'haa, 8'h01, 8'h3c};
		repeat (3) @(posedge clk);
		rstn <= 1;
		foreach (regs[i]) rdchk("reset", regs[i], 0);
		rdchk("unmapped", 10'h3ff, 0, RESP_SLVERR);
		wr(10'h3ff, 8'h00, RESP_SLVERR);
		$display("Test reset done");
		// Unused bits and pin configuration codes
		wr(IDX_CONTROL, 8'hfa);
		rdchk("control", IDX_CONTROL, 32'hf8);
		wr(IDX_PIN_CONFIG, 8'hff);
		rdchk("pincfg", IDX_PIN_CONFIG, 32'h07);
		for (int c = 7; c >= 0; c--) begin
			wr(IDX_PIN_CONFIG, 8'(c));
			nap();
			chk("pins", {24'h0, msk[c]}, {24'h0, ana.analog_pins});
			chk("ref", {31'h0, ext[c]}, {31'h0, ana.ref_external});
		end
		chk("chanvalid", 1, {31'h0, ana.chan_valid});
		chk("channel", 7, {29'h0, ana.channel});
		$display("Test pins done");
		// Every clock choice, channels 0, 3, 6, 1 and 4, flag and interrupt mask
		wr(IDX_REQ_ENABLE, 8'h40);
		wr(IDX_GLOBAL_IRQ, 8'hc0);
		for (int k = 0; k < 5; k++) begin
			ch = 3'(k * 3);
			wr(IDX_CONTROL, {2'(k), ch, 3'b101});
			wait_done();
			rdchk("result", IDX_RESULT, {24'h0, lv[ch]});
			rdchk("flag", IDX_REQ_FLAGS, 32'h40);
			nap();
			chk("irq", 1, {31'h0, irq});
			wr(IDX_REQ_ENABLE, 8'h00);
			nap();
			chk("masked", 0, {31'h0, irq});
			wr(IDX_REQ_ENABLE, 8'h40);
			wr(IDX_REQ_FLAGS, 8'h40);
			nap();
			chk("cleared", 0, {31'h0, irq});
			rdchk("flag", IDX_REQ_FLAGS, 0);
		end
		$display("Test convert done");
		// Divided clock stalls in sleep, RC clock runs on
		sleep <= 1;
		wr(IDX_CONTROL, {CLK_DIV2, 3'h3, 3'b101});
		repeat (150) @(posedge clk);
		rdchk("stalled", IDX_CONTROL, 32'h1d);
		sleep <= 0;
		wait_done();
		rdchk("result", IDX_RESULT, {24'h0, lv[3]});
		sleep <= 1;
		wr(IDX_CONTROL, {CLK_RC, 3'h2, 3'b101});
		wait_done();
		rdchk("result", IDX_RESULT, {24'h0, lv[2]});
		sleep <= 0;
		$display("Test sleep done");
		// Reset keeps the result; power-off aborts without flag
		rstn <= 0;
		repeat (3) @(posedge clk);
		rstn <= 1;
		rdchk("kept", IDX_RESULT, {24'h0, lv[2]});
		rdchk("control", IDX_CONTROL, 0);
		wr(IDX_CONTROL, 8'hc5);
		wr(IDX_CONTROL, 8'hc0);
		rdchk("abort", IDX_CONTROL, 32'hc0);
		rd(IDX_CONTROL, d, RESP_OKAY, 4);
		chk("late", 32'hc0, d);
		rdchk("noflag", IDX_REQ_FLAGS, 0);
		rdchk("kept", IDX_RESULT, {24'h0, lv[2]});
		$display("Test abort done");
		tally_and_finish();
	end
endmodule : adc_conversion_control_bench
